// ===== include/pmr_pkg.sv
// Package for the power misc control register bank
package pmr_pkg;
  // Register offsets
  localparam logic [7:0] REG3_OFF = 8'h37;
  localparam logic [7:0] THERM_OFF = 8'h38;
  localparam logic [7:0] BKUP_OFF = 8'h39;
  localparam logic [7:0] CONV_OFF = 8'h3e;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h3a;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h3b;
  // Field positions
  localparam int HD_FLAG_POS = 5;
  localparam int SD_FLAG_POS = 4;
  // Reset values
  localparam logic [4:0] VSEL_RST = 5'h00;
  localparam logic [1:0] SSTATE_RST = 2'h0;
  localparam logic [1:0] HDSEL_RST = 2'h3;
  localparam logic SD_EN_RST = 1'b1;
  localparam logic [1:0] BKLVL_RST = 2'h0;
  localparam logic BKEN_RST = 1'b0;
  localparam logic TRACK_RST = 1'b0;
  localparam logic [2:0] PSKIP_RST = 3'h7;
  localparam logic EXTCK_RST = 1'b0;
  localparam logic [1:0] SYNC_RST = 2'h1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Supply state codes
  localparam logic [1:0] SS_ACTIVE = 2'h1;
  localparam logic [1:0] SS_SLEEP = 2'h3;
  // Voltage codes in 100 mV units above 1 V floor
  localparam logic [4:0] VSEL_FLOOR = 5'h02;
  localparam logic [4:0] VSEL_MAX = 5'h19;
  localparam logic [5:0] MV100_BASE = 6'h0a;
  localparam logic [5:0] MV100_MAX = 6'h21;

  typedef struct packed {
    logic [4:0] vsel;
    logic [1:0] sstate;
    logic hd;
    logic sd;
    logic [1:0] hdsel;
    logic sd_en;
    logic [1:0] bklvl;
    logic bken;
    logic track;
    logic [2:0] pskip;
    logic extck;
    logic [1:0] sync;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
    logic reg3_on;
    logic reg3_sleep;
    logic [5:0] reg3_mv100;
    logic sd_active;
    logic conv_sync;
    logic conv_phase;
  } pmr_state_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmr_bus_s;
endpackage

// ===== src/pmr_regs.sv
// Power misc control register bank with thermal flags and interrupt
// Overview of operation
// - Supply state 00/10 off, 01 active high power, 11 sleep low power
// - Voltage code 0-2 gives 1 V, 3 gives 1.1 V, up to 3.3 V at 25
// - Voltage and supply state defaults load from boot configuration
// - Regulator three register lives in turn-off reset domain, resets to zero
// - Hot die flag reads 1 while selected hot die threshold reached
// - Shutdown flag reads 1 while shutdown threshold reached and monitor enable bit set
// - Hot die threshold select picks lowest to highest, resets to 3
// - Shutdown monitor enable bit resets to 1
// - Thermal bits 5:2 general reset, bit 0 turn-off reset only
// - Backup charge level 3.0, 2.52, 3.15 V or battery, resets 0
// - Backup charge enable resets 0, whole register general reset
// - Converter bits 6:3 turn-off reset, bits 2:0 general reset
// - Tracking bit makes regulator four follow core rail one, resets 0
// - Pulse skip enables for core two, core one, io rail reset to 1
// - External sync clock select muxes pad two, resets 0
// - Sync mode 00/10 none, 01 phase shift, 11 synchronous, resets 1
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pmr_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic turnoff_reset_i,
  input wire logic boot_load_i,
  input wire logic [4:0] boot_vsel_i,
  input wire logic [1:0] boot_sstate_i,
  input wire logic [2:0] boot_pskip_i,
  input wire logic [3:0] hot_die_level_i,
  input wire logic shutdown_level_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic reg3_on_o,
  output logic reg3_sleep_o,
  output logic [5:0] reg3_mv100_o,
  output logic shutdown_monitor_enable_o,
  output logic [1:0] hot_die_threshold_select_o,
  output logic [1:0] backup_charge_level_o,
  output logic backup_charge_enable_o,
  output logic track_o,
  output logic core_rail_two_pulse_skip_o,
  output logic core_rail_one_pulse_skip_o,
  output logic io_rail_pulse_skip_o,
  output logic ext_sync_clock_select_o,
  output logic conv_sync_o,
  output logic conv_phase_o
);
  pmr_pkg::pmr_state_s s_q, s_d;
  pmr_pkg::pmr_bus_s bus;
  logic [3:0] hd_s1_q, hd_s2_q;
  logic sd_s1_q, sd_s2_q;

  // Voltage code to 100 mV steps
  function automatic logic [5:0] vsel_to_mv100(input logic [4:0] code);
    logic [4:0] c;
    c = (code > pmr_pkg::VSEL_MAX) ? pmr_pkg::VSEL_MAX : code;
    if (c <= pmr_pkg::VSEL_FLOOR) begin
      vsel_to_mv100 = pmr_pkg::MV100_BASE;
    end else begin
      vsel_to_mv100 = pmr_pkg::MV100_BASE + {1'b0, c} - 6'h02;
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Two-flop synchronisers for analog detector levels
  always_ff @(posedge clk_i) begin
    hd_s1_q <= hot_die_level_i;
    hd_s2_q <= hd_s1_q;
    sd_s1_q <= shutdown_level_i;
    sd_s2_q <= sd_s1_q;
  end

  always_comb begin
    s_d = s_q;
    bus.addr = addr_i;
    bus.wdata = wdata_i;
    bus.wr = wr_i;
    bus.rd = rd_i;
    s_d.hd = hd_s2_q[s_q.hdsel];
    s_d.sd = sd_s2_q & s_q.sd_en;
    s_d.rdata = 8'h00;
    if (bus.wr) begin
      if (hit(bus.addr, pmr_pkg::REG3_OFF)) begin
        s_d.vsel = bus.wdata[6:2];
        s_d.sstate = bus.wdata[1:0];
      end
      if (hit(bus.addr, pmr_pkg::THERM_OFF)) begin
        s_d.hdsel = bus.wdata[3:2];
        s_d.sd_en = bus.wdata[0];
      end
      if (hit(bus.addr, pmr_pkg::BKUP_OFF)) begin
        s_d.bklvl = bus.wdata[2:1];
        s_d.bken = bus.wdata[0];
      end
      if (hit(bus.addr, pmr_pkg::CONV_OFF)) begin
        s_d.track = bus.wdata[6];
        s_d.pskip = bus.wdata[5:3];
        s_d.extck = bus.wdata[2];
        s_d.sync = bus.wdata[1:0];
      end
      if (hit(bus.addr, pmr_pkg::IRQ_MASK_OFF)) begin
        s_d.irq_mask = bus.wdata[1:0];
      end
    end
    if (bus.rd) begin
      if (hit(bus.addr, pmr_pkg::REG3_OFF)) begin
        s_d.rdata = {1'b0, s_q.vsel, s_q.sstate};
      end
      if (hit(bus.addr, pmr_pkg::THERM_OFF)) begin
        s_d.rdata = {2'h0, s_q.hd, s_q.sd, s_q.hdsel, 1'b0, s_q.sd_en};
      end
      if (hit(bus.addr, pmr_pkg::BKUP_OFF)) begin
        s_d.rdata = {5'h00, s_q.bklvl, s_q.bken};
      end
      if (hit(bus.addr, pmr_pkg::CONV_OFF)) begin
        s_d.rdata = {1'b0, s_q.track, s_q.pskip, s_q.extck, s_q.sync};
      end
      if (hit(bus.addr, pmr_pkg::IRQ_STAT_OFF)) begin
        s_d.rdata = {6'h00, s_q.irq_stat};
        s_d.irq_stat = 2'h0;
      end
      if (hit(bus.addr, pmr_pkg::IRQ_MASK_OFF)) begin
        s_d.rdata = {6'h00, s_q.irq_mask};
      end
    end
    // Rising flag edges set sticky status; set wins over read clear
    if (s_d.hd && !s_q.hd) begin
      s_d.irq_stat[1] = 1'b1;
    end
    if (s_d.sd && !s_q.sd) begin
      s_d.irq_stat[0] = 1'b1;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    s_d.reg3_on = s_d.sstate[0];
    s_d.reg3_sleep = (s_d.sstate == pmr_pkg::SS_SLEEP);
    s_d.reg3_mv100 = vsel_to_mv100(s_d.vsel);
    s_d.sd_active = s_d.sd_en;
    s_d.conv_sync = s_d.sync[0];
    s_d.conv_phase = (s_d.sync == pmr_pkg::SYNC_RST);
    // Boot configuration load of non-volatile fields
    if (boot_load_i) begin
      s_d.vsel = boot_vsel_i;
      s_d.sstate = boot_sstate_i;
      s_d.pskip = boot_pskip_i;
    end
    // General reset domain
    if (reset_i || turnoff_reset_i) begin
      s_d.hd = 1'b0;
      s_d.sd = 1'b0;
      s_d.hdsel = pmr_pkg::HDSEL_RST;
      s_d.bklvl = pmr_pkg::BKLVL_RST;
      s_d.bken = pmr_pkg::BKEN_RST;
      s_d.extck = pmr_pkg::EXTCK_RST;
      s_d.sync = pmr_pkg::SYNC_RST;
      s_d.irq_stat = pmr_pkg::IRQ_RST;
      s_d.irq_mask = pmr_pkg::IRQ_RST;
      s_d.rdata = 8'h00;
      s_d.irq = 1'b0;
      s_d.conv_sync = 1'b1;
      s_d.conv_phase = 1'b1;
    end
    // Turn-off reset domain
    if (turnoff_reset_i) begin
      s_d.vsel = pmr_pkg::VSEL_RST;
      s_d.sstate = pmr_pkg::SSTATE_RST;
      s_d.sd_en = pmr_pkg::SD_EN_RST;
      s_d.track = pmr_pkg::TRACK_RST;
      s_d.pskip = pmr_pkg::PSKIP_RST;
      s_d.reg3_on = 1'b0;
      s_d.reg3_sleep = 1'b0;
      s_d.reg3_mv100 = pmr_pkg::MV100_BASE;
      s_d.sd_active = pmr_pkg::SD_EN_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  assign rdata_o = s_q.rdata;
  assign irq_o = s_q.irq;
  assign reg3_on_o = s_q.reg3_on;
  assign reg3_sleep_o = s_q.reg3_sleep;
  assign reg3_mv100_o = s_q.reg3_mv100;
  assign shutdown_monitor_enable_o = s_q.sd_active;
  assign hot_die_threshold_select_o = s_q.hdsel;
  assign backup_charge_level_o = s_q.bklvl;
  assign backup_charge_enable_o = s_q.bken;
  assign track_o = s_q.track;
  assign core_rail_two_pulse_skip_o = s_q.pskip[2];
  assign core_rail_one_pulse_skip_o = s_q.pskip[1];
  assign io_rail_pulse_skip_o = s_q.pskip[0];
  assign ext_sync_clock_select_o = s_q.extck;
  assign conv_sync_o = s_q.conv_sync;
  assign conv_phase_o = s_q.conv_phase;
endmodule // pmr_regs
`default_nettype wire

// ===== bench/pmr_regs_properties.sv
// Concurrent checks for the power misc control register bank
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_properties (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic turnoff_reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic reg3_on_o,
  input wire logic reg3_sleep_o,
  input wire logic [5:0] reg3_mv100_o,
  input wire logic shutdown_monitor_enable_o,
  input wire logic [1:0] hot_die_threshold_select_o,
  input wire logic [1:0] backup_charge_level_o,
  input wire logic backup_charge_enable_o,
  input wire logic core_rail_two_pulse_skip_o,
  input wire logic core_rail_one_pulse_skip_o,
  input wire logic io_rail_pulse_skip_o,
  input wire logic ext_sync_clock_select_o,
  input wire logic track_o,
  input wire logic conv_sync_o,
  input wire logic conv_phase_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || turnoff_reset_i);
  sequence s_wr3; wr_i && addr_i == 8'h37; endsequence
  sequence s_wrc; wr_i && addr_i == 8'h3e; endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  a_res_bits: assert property (rd_i && addr_i == 8'h38 |=> rdata_o[7:6] == 2'h0 && !rdata_o[1])
    else $error("reserved thermal bits not zero");
  a_supply_decode: assert property (s_wr3 |=> reg3_on_o == $past(wdata_i[0]) &&
    reg3_sleep_o == ($past(wdata_i[1:0]) == 2'h3)) else $error("supply state decode wrong");
  a_volt_map: assert property (s_wr3 |=> reg3_mv100_o ==
    (($past(wdata_i[6:2]) <= 5'h02) ? 6'h0a : ($past(wdata_i[6:2]) >= 5'h19) ? 6'h21 :
    ({1'b0, $past(wdata_i[6:2])} + 6'h08))) else $error("voltage map wrong");
  a_sync_decode: assert property (s_wrc |=> conv_sync_o == $past(wdata_i[0]) &&
    conv_phase_o == ($past(wdata_i[1:0]) == 2'h1)) else $error("sync decode wrong");
  a_track_bit: assert property (s_wrc |=> track_o == $past(wdata_i[6]))
    else $error("tracking bit wrong");
  a_turnoff_rst: assert property (@(posedge clk_i) turnoff_reset_i |=>
    reg3_mv100_o == 6'h0a && !reg3_on_o && shutdown_monitor_enable_o && !track_o)
    else $error("turn-off reset values wrong");
  a_gen_rst: assert property (@(posedge clk_i) disable iff (turnoff_reset_i) reset_i |=>
    conv_sync_o && conv_phase_o && !backup_charge_enable_o) else $error("general reset wrong");
  a_conv_copy: assert property (s_wrc |=> {core_rail_two_pulse_skip_o,
    core_rail_one_pulse_skip_o, io_rail_pulse_skip_o, ext_sync_clock_select_o} ==
    $past(wdata_i[5:2])) else $error("converter field copy wrong");
  a_backup_copy: assert property (wr_i && addr_i == 8'h39 |=>
    backup_charge_level_o == $past(wdata_i[2:1]) && backup_charge_enable_o == $past(wdata_i[0]))
    else $error("backup field copy wrong");
  a_hdsel_copy: assert property (wr_i && addr_i == 8'h38 |=>
    hot_die_threshold_select_o == $past(wdata_i[3:2])) else $error("threshold select copy wrong");
  a_turnoff_keep: assert property (@(posedge clk_i) disable iff (turnoff_reset_i)
    reset_i && !wr_i |=> $stable(track_o) && $stable(shutdown_monitor_enable_o))
    else $error("turn-off field lost in general reset");
endmodule // pmr_regs_properties
bind pmr_regs pmr_regs_properties u_props (.clk_i, .reset_i, .turnoff_reset_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .reg3_on_o, .reg3_sleep_o, .reg3_mv100_o,
  .shutdown_monitor_enable_o, .hot_die_threshold_select_o, .backup_charge_level_o,
  .backup_charge_enable_o, .core_rail_two_pulse_skip_o, .core_rail_one_pulse_skip_o,
  .io_rail_pulse_skip_o, .ext_sync_clock_select_o, .track_o, .conv_sync_o, .conv_phase_o);
`default_nettype wire

// ===== bench/pmr_regs_bench.sv
// Testbench for the power misc control register bank
`timescale 1ns/1ps
`default_nettype none
module pmr_regs_bench;
  logic clk_i = 0, reset_i = 1, turnoff_reset_i = 1, boot_load_i = 0, sd_i = 0, wr_i = 0, rd_i = 0;
  logic [4:0] bv_i = 5'h03;
  logic [1:0] bs_i = 2'h1;
  logic [2:0] bp_i = 3'h2;
  logic [3:0] hd_i = 4'h0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic irq_o, on_o, sl_o;
  logic [5:0] mv_o;
  int errors = 0, num_checks = 0;
  pmr_regs u_dut (.clk_i(clk_i), .reset_i(reset_i), .turnoff_reset_i(turnoff_reset_i),
    .boot_load_i(boot_load_i), .boot_vsel_i(bv_i), .boot_sstate_i(bs_i), .boot_pskip_i(bp_i),
    .hot_die_level_i(hd_i), .shutdown_level_i(sd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .reg3_on_o(on_o),
    .reg3_sleep_o(sl_o), .reg3_mv100_o(mv_o), .shutdown_monitor_enable_o(),
    .hot_die_threshold_select_o(), .backup_charge_level_o(), .backup_charge_enable_o(),
    .track_o(), .core_rail_two_pulse_skip_o(), .core_rail_one_pulse_skip_o(),
    .io_rail_pulse_skip_o(), .ext_sync_clock_select_o(), .conv_sync_o(), .conv_phase_o());
  initial forever #2 clk_i = ~clk_i;
  task ck(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
    @(posedge clk_i); wr_i <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i); addr_i <= a; rd_i <= 1;
    @(posedge clk_i); rd_i <= 0;
    #1 ck(rdata_o, e);
  endtask
  task rst(input logic t, input int n);
    @(posedge clk_i); reset_i <= 1; turnoff_reset_i <= t;
    repeat (n) @(posedge clk_i);
    reset_i <= 0; turnoff_reset_i <= 0;
  endtask
  task t_reset_vals;
    rd(8'h37, 8'h00); rd(8'h38, 8'h0d); rd(8'h39, 8'h00);
    rd(8'h3e, 8'h39); rd(8'h3a, 8'h00); rd(8'h3b, 8'h00);
    wr(8'h50, 8'hff); rd(8'h50, 8'h00);
    $display("t_reset_vals done");
  endtask
  task t_reg3;
    logic [4:0] vs [4] = '{5'h00, 5'h02, 5'h03, 5'h19};
    logic [5:0] mv [4] = '{6'h0a, 6'h0a, 6'h0b, 6'h21};
    for (int i = 0; i < 4; i++) begin
      wr(8'h37, {1'b1, vs[i], 2'(i)});
      @(posedge clk_i); #1 ck(8'(mv_o), 8'(mv[i]));
      ck({6'h00, sl_o, on_o}, {6'h00, i == 3, 1'(i)});
      rd(8'h37, {1'b0, vs[i], 2'(i)});
    end
    $display("t_reg3 done");
  endtask
  task t_thermal;
    wr(8'h3b, 8'h03); wr(8'h38, 8'hc7);
    hd_i <= 4'h2; sd_i <= 1;
    repeat (6) @(posedge clk_i);
    rd(8'h38, 8'h35);
    ck(8'(irq_o), 8'h01);
    rd(8'h3a, 8'h03); @(posedge clk_i); #1 ck(8'(irq_o), 8'h00);
    wr(8'h38, 8'h04); rd(8'h38, 8'h24);
    hd_i <= 4'h0; sd_i <= 0;
    repeat (6) @(posedge clk_i);
    $display("t_thermal done");
  endtask
  task t_domains;
    wr(8'h38, 8'h00); wr(8'h39, 8'h07); wr(8'h3e, 8'hff); rd(8'h3e, 8'h7f);
    rst(0, 2); rd(8'h38, 8'h0c); rd(8'h39, 8'h00); rd(8'h3e, 8'h79);
    rst(1, 2); rd(8'h38, 8'h0d); rd(8'h3e, 8'h39);
    $display("t_domains done");
  endtask
  task t_boot;
    @(posedge clk_i); boot_load_i <= 1;
    @(posedge clk_i); boot_load_i <= 0;
    rd(8'h37, 8'h0d); rd(8'h3e, 8'h11); ck(8'(on_o), 8'h01);
    $display("t_boot done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    rst(1, 20);
    t_reset_vals; t_reg3; t_thermal; t_domains; t_boot;
    finish_test;
  end
  initial begin
    #20000;
    errors++;
    finish_test;
  end
endmodule // pmr_regs_bench
`default_nettype wire
